// ### logic/vrt_pkg.sv
// Constants for the reference and temperature control register block
package vrt_pkg;
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] status_addr = 8'h01;
   localparam int enable_bit = 7;
   localparam int ready_bit = 6;
   localparam int temp_enable_bit = 5;
   localparam int temp_range_bit = 4;
   localparam int cmp_gain_lsb = 2;
   localparam int adc_gain_lsb = 0;
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [7:0] writable_mask = 8'hbf;
   localparam int clk_mhz = 100;
   localparam int settle_ns = 20000;
   localparam int settle_cycles = (settle_ns * clk_mhz + 999) / 1000;
   localparam int buffer_ns = 30000;
   localparam int buffer_cycles = (buffer_ns * clk_mhz + 999) / 1000;
   localparam int temp_wait_ns = 200000;
   localparam int temp_wait_cycles = (temp_wait_ns * clk_mhz + 999) / 1000;
   localparam logic [1:0] gain_off = 2'h0;
   localparam logic [1:0] gain_x1 = 2'h1;
   localparam logic [1:0] gain_x2 = 2'h2;
   localparam logic [1:0] gain_x4 = 2'h3;
   typedef enum logic [1:0] {
      ref_off = 2'b00,
      ref_settling = 2'b01,
      ref_ready = 2'b10
   } vrt_ref_state_type;
endpackage : vrt_pkg

// ### logic/vrt_settle_timer.sv
// Down counter that reports when a settling interval has elapsed
`timescale 1ns/1ps
module vrt_settle_timer #(
   parameter int width = 16
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic restart,
   input wire logic hold_off,
   input wire logic [width-1:0] load_value,
   output logic done
);
   typedef struct packed {
      logic [width-1:0] count;
      logic done;
   } vrt_timer_state_type;

   vrt_timer_state_type state;
   vrt_timer_state_type next_state;

   always_comb begin
      next_state = state;
      if (hold_off) begin
         next_state.count = '0;
         next_state.done = 1'b0;
      end else if (restart) begin
         next_state.count = load_value;
         next_state.done = 1'b0;
      end else if (state.count > width'(1)) begin
         next_state.count = state.count - width'(1);
      end else begin
         next_state.count = '0;
         next_state.done = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= '0;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   assign done = state.done;
endmodule : vrt_settle_timer

// ### logic/vrt_control.sv
// Fixed reference and temperature indicator control register
//
// What this block does
// - Reference enable output follows control bit 7.
// - Ready flag at bit 6 reads one only when reference output is usable.
// - On the standard-voltage variant the ready flag always reads one.
// - Temperature indicator enable output follows control bit 5.
// - Range output follows bit 4: one high range, zero low range.
// - Bits 3-2 set comparator/DAC buffer gain: 11 x4, 10 x2, 01 x1, 00 off.
// - Bits 1-0 set ADC buffer gain with the same encoding.
// - All writable bits reset to zero on every reset.
// - Temperature indicator is routed to the ADC while the dedicated ADC channel select input and control bit 5 are both high.
// - Ready sets only after the reference has settled following enable.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module vrt_control #(
   parameter bit standard_variant = 1'b0,
   parameter int settle_count = vrt_pkg::settle_cycles
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic adc_temp_channel_sel,
   output logic [7:0] rdata,
   output logic reference_enable,
   output logic temp_sense_enable,
   output logic temp_range_select,
   output logic [1:0] cmp_dac_buffer_gain,
   output logic [1:0] adc_buffer_gain,
   output logic temp_to_adc,
   output logic cmp_buffer_ready,
   output logic adc_buffer_ready,
   output logic temp_sample_ok
);
   typedef struct packed {
      logic [7:0] ctrl;
      vrt_pkg::vrt_ref_state_type ref_state;
      logic [7:0] rdata;
      logic temp_to_adc;
      logic [1:0] cmp_gain_prev;
      logic [1:0] adc_gain_prev;
      logic temp_route_prev;
   } vrt_state_type;

   vrt_state_type state;
   vrt_state_type next_state;
   logic ref_done;
   logic cmp_done;
   logic adc_done;
   logic temp_done;
   logic ready;
   logic [7:0] status_word;

   function automatic logic buffer_on(input logic [1:0] gain);
      buffer_on = (gain != vrt_pkg::gain_off);
   endfunction : buffer_on

   ////////////////////////////////////////////////////////////////////////////////
   // Field decoding
   function automatic logic [1:0] cmp_gain_of(input logic [7:0] ctrl);
      cmp_gain_of = ctrl[vrt_pkg::cmp_gain_lsb +: 2];
   endfunction : cmp_gain_of

   function automatic logic [1:0] adc_gain_of(input logic [7:0] ctrl);
      adc_gain_of = ctrl[vrt_pkg::adc_gain_lsb +: 2];
   endfunction : adc_gain_of

   // Stored bits with the live ready flag in place of the unwritable one
   function automatic logic [7:0] ctrl_image(input logic [7:0] ctrl, input logic rdy);
      ctrl_image = ctrl;
      ctrl_image[vrt_pkg::ready_bit] = rdy;
   endfunction : ctrl_image

   // Unmapped addresses read as zero rather than aliasing a register
   function automatic logic [7:0] read_word(
      input logic [7:0] a,
      input logic [7:0] ctrl,
      input logic rdy,
      input logic [7:0] status
   );
      case (a)
         vrt_pkg::ctrl_addr: begin
            read_word = ctrl_image(ctrl, rdy);
         end
         vrt_pkg::status_addr: begin
            read_word = status;
         end
         default: begin
            read_word = 8'h00;
         end
      endcase
   endfunction : read_word

   // Any disable drops straight to off so a re-enable always settles afresh
   function automatic vrt_pkg::vrt_ref_state_type step_ref(
      input vrt_pkg::vrt_ref_state_type cur,
      input logic enable,
      input logic settled
   );
      step_ref = cur;
      case (cur)
         vrt_pkg::ref_off: begin
            if (enable) begin
               step_ref = vrt_pkg::ref_settling;
            end
         end
         vrt_pkg::ref_settling: begin
            if (!enable) begin
               step_ref = vrt_pkg::ref_off;
            end else if (settled) begin
               step_ref = vrt_pkg::ref_ready;
            end
         end
         vrt_pkg::ref_ready: begin
            if (!enable) begin
               step_ref = vrt_pkg::ref_off;
            end
         end
         default: begin
            step_ref = vrt_pkg::ref_off;
         end
      endcase
   endfunction : step_ref

   ////////////////////////////////////////////////////////////////////////////////
   // Ready flag
   // A disable write clears the flag at once rather than one state step later
   assign ready = standard_variant ? 1'b1 :
      (state.ref_state == vrt_pkg::ref_ready && state.ctrl[vrt_pkg::enable_bit]);

   assign status_word = {5'h00, temp_done, adc_done, cmp_done};

   always_comb begin
      next_state = state;
      next_state.rdata = 8'h00;
      next_state.cmp_gain_prev = cmp_gain_of(state.ctrl);
      next_state.adc_gain_prev = adc_gain_of(state.ctrl);
      next_state.temp_route_prev = state.temp_to_adc;
      // Sensor routed only while it is both enabled and selected
      next_state.temp_to_adc = adc_temp_channel_sel & state.ctrl[vrt_pkg::temp_enable_bit];
      if (wr_en && addr == vrt_pkg::ctrl_addr) begin
         next_state.ctrl = wdata & vrt_pkg::writable_mask;
      end
      if (rd_en) begin
         next_state.rdata = read_word(addr, state.ctrl, ready, status_word);
      end
      next_state.ref_state = step_ref(state.ref_state, state.ctrl[vrt_pkg::enable_bit],
         ref_done);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= '0;
         state.ctrl <= vrt_pkg::ctrl_reset;
         state.ref_state <= vrt_pkg::ref_off;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Settling timers
   vrt_settle_timer #(.width(16)) u_ref_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .restart(state.ref_state == vrt_pkg::ref_off),
      .hold_off(!state.ctrl[vrt_pkg::enable_bit]),
      .load_value(16'(settle_count)),
      .done(ref_done)
   );

   // Buffer readiness is a helper for software; it does not gate the outputs
   vrt_settle_timer #(.width(16)) u_cmp_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .restart(!buffer_on(state.cmp_gain_prev)),
      .hold_off(!buffer_on(cmp_gain_of(state.ctrl))),
      .load_value(16'(vrt_pkg::buffer_cycles)),
      .done(cmp_done)
   );

   vrt_settle_timer #(.width(16)) u_adc_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .restart(!buffer_on(state.adc_gain_prev)),
      .hold_off(!buffer_on(adc_gain_of(state.ctrl))),
      .load_value(16'(vrt_pkg::buffer_cycles)),
      .done(adc_done)
   );

   // Restarted each time the sensor is newly routed; software re-waits between samples
   vrt_settle_timer #(.width(16)) u_temp_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .restart(!state.temp_route_prev),
      .hold_off(!state.temp_to_adc),
      .load_value(16'(vrt_pkg::temp_wait_cycles)),
      .done(temp_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign rdata = state.rdata;
   assign reference_enable = state.ctrl[vrt_pkg::enable_bit];
   assign temp_sense_enable = state.ctrl[vrt_pkg::temp_enable_bit];
   assign temp_range_select = state.ctrl[vrt_pkg::temp_range_bit];
   assign cmp_dac_buffer_gain = cmp_gain_of(state.ctrl);
   assign adc_buffer_gain = adc_gain_of(state.ctrl);
   assign temp_to_adc = state.temp_to_adc;
   assign cmp_buffer_ready = cmp_done;
   assign adc_buffer_ready = adc_done;
   assign temp_sample_ok = temp_done;
endmodule : vrt_control

// ### test/vrt_control_properties.sv
// Port checker for the reference control register
`timescale 1ns/1ps
module vrt_ctl_checker #(
   parameter bit standard_variant = 1'b0,
   parameter int settle_count = 10
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic adc_temp_channel_sel,
   input wire logic [7:0] rdata,
   input wire logic reference_enable,
   input wire logic temp_sense_enable,
   input wire logic temp_range_select,
   input wire logic [1:0] cmp_dac_buffer_gain,
   input wire logic [1:0] adc_buffer_gain,
   input wire logic temp_to_adc
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire wr0 = clk_en && wr_en && addr == vrt_pkg::ctrl_addr;
   wire rd0 = clk_en && rd_en && addr == vrt_pkg::ctrl_addr;
   wire rd0_var = !standard_variant && rd0;
   wire rd0_std = standard_variant && rd0;
   ////////////////////////////////////////
   AST_REF_EN: assert property (wr0 |=> reference_enable == $past(wdata[7]))
      else $error("reference enable not taken from write");
   AST_TEMP_EN: assert property (wr0 |=> temp_sense_enable == $past(wdata[5]))
      else $error("sensor enable not taken from write");
   AST_RANGE: assert property (wr0 |=> temp_range_select == $past(wdata[4]))
      else $error("range not taken from write");
   AST_CMP_GAIN: assert property (wr0 |=> cmp_dac_buffer_gain == $past(wdata[3:2]))
      else $error("comparator gain wrong");
   AST_ADC_GAIN: assert property (wr0 |=> adc_buffer_gain == $past(wdata[1:0]))
      else $error("adc gain wrong");
   AST_RDY_OFF: assert property (rd0_var && !reference_enable |=> !rdata[6])
      else $error("ready while disabled");
   AST_RDY_EARLY: assert property (rd0_var && !$past(reference_enable, 5) |=> !rdata[6])
      else $error("ready before settling");
   AST_RDY_STD: assert property (rd0_std |=> rdata[6])
      else $error("standard variant ready not set");
   AST_READBACK: assert property (rd0 |=> {rdata[7], rdata[5:0]} == $past({reference_enable,
      temp_sense_enable, temp_range_select, cmp_dac_buffer_gain, adc_buffer_gain}))
      else $error("readback differs from stored bits");
   AST_TEMP_CH: assert property (clk_en |=>
      temp_to_adc == $past(adc_temp_channel_sel && temp_sense_enable))
      else $error("sensor channel wrong");
   cover property (rd0 ##1 rdata[6]);
   cover property (temp_to_adc);
   cover property (wr0 && wdata[3:2] == 2'h3);
endmodule : vrt_ctl_checker
bind vrt_control vrt_ctl_checker #(.standard_variant(standard_variant),
   .settle_count(settle_count)) i_chk (.sys_clk(sys_clk),
   .reset(reset), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
   .adc_temp_channel_sel(adc_temp_channel_sel), .rdata(rdata),
   .reference_enable(reference_enable), .temp_sense_enable(temp_sense_enable),
   .temp_range_select(temp_range_select), .cmp_dac_buffer_gain(cmp_dac_buffer_gain),
   .adc_buffer_gain(adc_buffer_gain), .temp_to_adc(temp_to_adc));

// ### test/vrt_analog_model.sv
// Far side model: ADC input mux and conversion gate
`timescale 1ns/1ps
module vrt_analog_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic route_req,
   input wire logic temp_sample_ok,
   input wire logic buf_ok,
   output logic adc_temp_channel_sel,
   output logic convert
);
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         adc_temp_channel_sel <= 1'b0;
      end else begin
         adc_temp_channel_sel <= route_req;
      end
   end
   // Never converts before both waits have run out
   assign convert = temp_sample_ok && buf_ok;
endmodule : vrt_analog_model

// ### test/tb_top.sv
// Self-checking bench for the reference control register
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic route = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic sel, tta, ref_en, ts_en, ts_rng, c_rdy, a_rdy, ts_ok;
   logic [1:0] cmp_g, adc_g;
   logic [7:0] rdata, rdata_std;
   int fail_count = 0;
   int n_tests = 0;
   localparam logic [7:0] ctl = vrt_pkg::ctrl_addr;
   vrt_control #(.settle_count(10)) i_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .adc_temp_channel_sel(sel),
      .rdata(rdata), .reference_enable(ref_en), .temp_sense_enable(ts_en),
      .temp_range_select(ts_rng), .cmp_dac_buffer_gain(cmp_g), .adc_buffer_gain(adc_g),
      .temp_to_adc(tta), .cmp_buffer_ready(c_rdy), .adc_buffer_ready(a_rdy),
      .temp_sample_ok(ts_ok));
   vrt_control #(.standard_variant(1'b1), .settle_count(10)) i_dut_std (.sys_clk(sys_clk),
      .reset(reset), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .adc_temp_channel_sel(sel), .rdata(rdata_std), .reference_enable(),
      .temp_sense_enable(), .temp_range_select(), .cmp_dac_buffer_gain(), .adc_buffer_gain(),
      .temp_to_adc(), .cmp_buffer_ready(), .adc_buffer_ready(), .temp_sample_ok());
   vrt_analog_model i_far (.sys_clk(sys_clk), .reset(reset), .route_req(route),
      .temp_sample_ok(ts_ok), .buf_ok(c_rdy && a_rdy), .adc_temp_channel_sel(sel), .convert());
   initial forever #5 sys_clk = ~sys_clk;
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 q = rdata;
   endtask : rd
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////
   task automatic t_reset;
      logic [7:0] q;
      chk({ref_en, 1'b0, ts_en, ts_rng, cmp_g, adc_g}, vrt_pkg::ctrl_reset);
      rd(ctl, q);
      chk(q, vrt_pkg::ctrl_reset);
      chk({7'h00, rdata_std[6]}, 8'h01);
      $display("reset test done");
   endtask : t_reset
   task automatic t_fields;
      logic [7:0] q;
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {2'b01, i[0], i[1], i[1:0], 2'(3 - i)};
         wr(ctl, v);
         chk({2'h0, ts_en, ts_rng, cmp_g, adc_g}, {2'h0, v[5:0]});
         rd(ctl, q);
         chk(q, v & vrt_pkg::writable_mask);
      end
      $display("field test done");
   endtask : t_fields
   // A write while the clock enable is low must leave every stored bit alone
   task automatic t_freeze;
      logic [7:0] q;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(ctl, 8'h83);
      chk({2'h0, ts_en, ts_rng, cmp_g, adc_g}, 8'h3c);
      chk({7'h00, ref_en}, 8'h00);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(ctl, q);
      chk(q, 8'h3c);
      $display("freeze test done");
   endtask : t_freeze
   task automatic t_ready;
      logic [7:0] q;
      int n;
      wr(ctl, 8'h80);
      chk({7'h00, ref_en}, 8'h01);
      rd(ctl, q);
      chk(q, 8'h80);
      n = 0;
      do begin
         rd(ctl, q);
         n++;
      end while (q[6] !== 1'b1 && n < 30);
      chk(q, 8'hc0);
      wr(ctl, 8'h00);
      chk({7'h00, ref_en}, 8'h00);
      repeat (2) @(posedge sys_clk);
      rd(ctl, q);
      chk(q, 8'h00);
      rd(8'h55, q);
      chk(q, 8'h00);
      wr(8'h77, 8'hff);
      rd(ctl, q);
      chk(q, 8'h00);
      $display("ready test done");
      if (n == 30) begin
         fail_count++;
         conclude();
      end
   endtask : t_ready
   task automatic t_temp;
      @(posedge sys_clk);
      route <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk({7'h00, tta}, 8'h00);
      wr(ctl, 8'h20);
      @(posedge sys_clk);
      #1 chk({7'h00, tta}, 8'h01);
      $display("sensor test done");
   endtask : t_temp
   task automatic t_status;
      logic [7:0] q;
      int n;
      wr(ctl, 8'h25);
      repeat (vrt_pkg::buffer_cycles - 1) @(posedge sys_clk);
      #1 chk({6'h00, a_rdy, c_rdy}, 8'h00);
      n = 0;
      while ({a_rdy, c_rdy} !== 2'b11 && n < 8) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk({6'h00, a_rdy, c_rdy}, 8'h03);
      if ({a_rdy, c_rdy} !== 2'b11) conclude();
      rd(vrt_pkg::status_addr, q);
      chk(q, 8'h03);
      @(posedge sys_clk);
      route <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk({7'h00, ts_ok}, 8'h00);
      @(posedge sys_clk);
      route <= 1'b1;
      repeat (vrt_pkg::temp_wait_cycles) @(posedge sys_clk);
      #1 chk({7'h00, ts_ok}, 8'h00);
      n = 0;
      while (ts_ok !== 1'b1 && n < 8) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk({7'h00, ts_ok}, 8'h01);
      if (ts_ok !== 1'b1) conclude();
      rd(vrt_pkg::status_addr, q);
      chk(q, 8'h07);
      $display("status test done");
   endtask : t_status
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      #1;
      t_reset();
      t_fields();
      t_freeze();
      t_ready();
      t_temp();
      t_status();
      @(posedge sys_clk);
      reset <= 1'b1;
      @(posedge sys_clk);
      reset <= 1'b0;
      #1;
      t_reset();
      conclude();
   end
endmodule : tb_top
